// *** dfd_pkg.sv ***
/*
 * Shared constants and types for the instruction field decoder: field
 * positions inside the 16-bit instruction word, operation encodings and the
 * packed control word handed to the datapath.
 * Assumes a single-clock core in which fetch, decode and datapath share clk.
 */
package dfd_pkg;

    localparam int INSTR_W = 16;

    // Field positions inside the instruction word.
    localparam int DEST_BIT = 10;
    localparam int XFER_BIT = 10;
    localparam int SRC_BIT = 9;
    localparam int F1_LSB = 5;
    localparam int F2_LSB = 5;
    localparam int F3_LSB = 5;
    localparam int FUNC_W = 4;
    localparam int X_BIT = 4;
    localparam int YZ_LSB = 0;
    localparam int YZ_W = 4;
    localparam int COND_LSB = 0;
    localparam int COND_W = 5;
    localparam int MOVE_LSB = 4;
    localparam int MOVE_W = 6;
    localparam int BR_LSB = 8;
    localparam int BR_W = 3;
    localparam int SHORT_LSB = 9;
    localparam int SOFT_INT_BIT = 10;
    localparam int NI_LSB = 7;
    localparam int NI_W = 4;
    localparam int K_LSB = 0;
    localparam int K_W = 7;
    localparam int DIR_BIT = 10;
    localparam int DIRECT_REG_LSB = 6;
    localparam int DIRECT_REG_W = 4;
    localparam int THREE_OPERAND_SOURCE_SELECT_LSB = 3;
    localparam int F4_HI_LSB = 6;
    localparam int F4_LO_BIT = 4;
    localparam int AUX_LSB = 0;
    localparam int AUX_W = 4;
    localparam int JUMP_W = 12;

    // Condition codes with fixed meaning and the last defined one.
    localparam logic [4:0] COND_ALWAYS = 5'h0e;
    localparam logic [4:0] COND_NEVER = 5'h0f;
    localparam logic [4:0] COND_LAST = 5'h1c;
    localparam int COND_N = 29;

    // Data-move register groups.
    localparam logic [5:0] MOVE_PTR_BASE = 6'h00;
    localparam logic [5:0] MOVE_ACC_BASE = 6'h30;

    typedef enum logic [3:0] {
        mac_mpy, mac_mpy_add, mac_prod, mac_mpy_sub,
        mac_load_p, mac_add_p, mac_nop, mac_sub_p,
        mac_or_y, mac_xor_y, mac_test_and_y, mac_cmp_y,
        mac_load_y, mac_add_y, mac_and_y, mac_sub_y
    } dfd_mac_op_t;

    typedef enum logic [3:0] {
        sf_shr1, sf_shl1, sf_shr4, sf_shl4, sf_shr8, sf_shl8, sf_shr16, sf_shl16,
        sf_load_p, sf_inc_high, sf_ones_comp, sf_round,
        sf_load_y, sf_inc, sf_copy, sf_negate
    } dfd_sf_op_t;

    typedef enum logic [1:0] {pm_none, pm_inc1, pm_incj} dfd_ptr_mod_t;
    typedef enum logic [1:0] {cm_zp, cm_pz, cm_m2, cm_jk} dfd_comp_mode_t;
    typedef enum logic [2:0] {
        br_return, br_ireturn, br_goto_ptr, br_call_ptr, br_none
    } dfd_br_t;
    typedef enum logic [2:0] {
        a3_none, a3_or, a3_xor, a3_test_and, a3_test_sub, a3_add, a3_and, a3_sub
    } dfd_alu3_op_t;
    typedef enum logic [1:0] {
        s3_low_imm, s3_src_xfer, s3_high_imm, s3_src_prod
    } dfd_src3_t;
    typedef enum logic [4:0] {
        bm_none,
        bm_arith_r_aux, bm_arith_l_aux, bm_logic_r_aux, bm_logic_l_aux,
        bm_arith_r_src, bm_arith_l_src, bm_logic_r_src, bm_logic_l_src,
        bm_arith_r_imm, bm_arith_l_imm, bm_logic_r_imm, bm_logic_l_imm,
        bm_exp, bm_norm, bm_exts_imm, bm_exts_aux, bm_extz_imm, bm_extz_aux,
        bm_ins_imm, bm_ins_aux, bm_alt_acc0, bm_alt_acc1
    } dfd_bmu_op_t;

    typedef struct packed {
        logic valid;
        logic dest_acc;
        logic src_acc;
        logic xfer_acc;
        dfd_mac_op_t mac_op;
        logic mac_writes_dest;
        logic coef_inc_by_index;
        logic half_high;
        logic [1:0] ptr_sel;
        dfd_ptr_mod_t ptr_mod;
        logic [1:0] comp_ptr_sel;
        dfd_comp_mode_t comp_mode;
        dfd_sf_op_t sf_op;
        logic [4:0] cond_code;
        logic cond_true;
        logic cond_reserved;
        logic [5:0] move_reg;
        logic move_is_ptr;
        logic move_is_acc_half;
        logic move_reserved;
        dfd_br_t br_type;
        logic br_reserved;
        logic [1:0] short_pair;
        logic soft_int;
        logic qualifier;
        logic cache_redo;
        logic [NI_W-1:0] cache_count;
        logic [K_W-1:0] cache_iter;
        logic direct_read;
        logic [DIRECT_REG_W-1:0] direct_reg;
        dfd_alu3_op_t alu3_op;
        logic alu3_writes_dest;
        logic alu3_reserved;
        dfd_src3_t alu3_src;
        dfd_bmu_op_t bmu_op;
        logic [1:0] bmu_aux;
        logic bmu_reserved;
        logic [JUMP_W-1:0] jump_target;
    } dfd_ctl_t;

endpackage

// *** dfd_decoder.sv ***
/*
 * Instruction field decoder. Every cycle the fetched word is split into all
 * of its operand and function fields in parallel and the decoded controls
 * are registered into one control word for the datapath and the address
 * generators. Which format applies is chosen downstream from the type field.
 * Assumes the word, the condition flags and the loop-count register value
 * come from logic on the same clock, so none of them is synchronised.
 */

// Overview of operation
// - Source bit 0 selects accumulator zero, 1 selects accumulator one.
// - Transfer bit is inverted: 0 selects accumulator one, 1 accumulator zero.
// - Multiply/ALU code maps to sixteen operations; two compare codes, product and nop write nothing.
// - Two-operand form: X bit picks pointer step of one or index.
// - One-operand form: X bit picks low or high half.
// - Indirect field: top bits pick pointer, low bits pick none, +1 or +j.
// - Compound field: top bits pick pointer, low bits pick zp, pz, m2, jk.
// - Special function code maps to shifts, loads, increments, complement, round, negate.
// - Condition codes up to 28 defined; 14 always true, 15 never; rest reserved.
// - Move register field maps core and peripheral registers; some codes reserved.
// - Branch type: return, interrupt return, goto or call via pointer; top bit reserved.
// - Short-immediate field picks one of four register pairs.
// - Qualifier with interrupt bit set is a software interrupt, else a qualifier.
// - Cache-loop count field gives the number of instructions cached.
// - A cache count of zero means redo the block already cached.
// - Repeat field gives how many times the cached block runs.
// - A repeat field of zero takes the count from the loop-count register.
// - Direct move: direction 0 writes register to memory, 1 reads memory.
// - Three-operand ALU code maps to five writing and two test-only operations.
// - Operand select picks low/high half with immediate, transfer or product.
// - Bit-manipulation function and auxiliary fields decode together; xx picks aux register.
// - Destination bit 0 selects accumulator zero, 1 selects accumulator one.
module dfd_decoder (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [dfd_pkg::INSTR_W-1:0] instr,
    input wire logic [dfd_pkg::COND_N-1:0] cond_flags,
    input wire logic [dfd_pkg::K_W-1:0] loop_count,
    output dfd_pkg::dfd_ctl_t ctl
);

    dfd_pkg::dfd_ctl_t q;
    dfd_pkg::dfd_ctl_t next_q;

    logic [3:0] f1_code;
    logic [3:0] f2_code;
    logic [3:0] f3_code;
    logic [3:0] f4_code;
    logic [3:0] aux_code;
    logic [3:0] yz_code;
    logic [4:0] cond_code;
    logic [5:0] move_code;
    logic [2:0] br_code;
    logic [dfd_pkg::NI_W-1:0] ni_code;
    logic [dfd_pkg::K_W-1:0] k_code;

    assign f1_code = instr[dfd_pkg::F1_LSB +: dfd_pkg::FUNC_W];
    assign f2_code = instr[dfd_pkg::F2_LSB +: dfd_pkg::FUNC_W];
    assign f3_code = instr[dfd_pkg::F3_LSB +: dfd_pkg::FUNC_W];
    // The function bits of the bit-manipulation form are split around bit 5.
    assign f4_code = {instr[dfd_pkg::F4_HI_LSB +: 3], instr[dfd_pkg::F4_LO_BIT]};
    assign aux_code = instr[dfd_pkg::AUX_LSB +: dfd_pkg::AUX_W];
    assign yz_code = instr[dfd_pkg::YZ_LSB +: dfd_pkg::YZ_W];
    assign cond_code = instr[dfd_pkg::COND_LSB +: dfd_pkg::COND_W];
    assign move_code = instr[dfd_pkg::MOVE_LSB +: dfd_pkg::MOVE_W];
    assign br_code = instr[dfd_pkg::BR_LSB +: dfd_pkg::BR_W];
    assign ni_code = instr[dfd_pkg::NI_LSB +: dfd_pkg::NI_W];
    assign k_code = instr[dfd_pkg::K_LSB +: dfd_pkg::K_W];

    always_comb begin
        next_q = '0;
        next_q.valid = instr_valid;

        // Accumulator selections.
        next_q.dest_acc = instr[dfd_pkg::DEST_BIT];
        next_q.src_acc = instr[dfd_pkg::SRC_BIT];
        next_q.xfer_acc = ~instr[dfd_pkg::XFER_BIT];

        // Multiply/ALU function; codes 1010 and 1011 only set flags.
        next_q.mac_op = dfd_pkg::dfd_mac_op_t'(f1_code);
        case (next_q.mac_op)
            dfd_pkg::mac_prod,
            dfd_pkg::mac_nop,
            dfd_pkg::mac_test_and_y,
            dfd_pkg::mac_cmp_y: begin
                next_q.mac_writes_dest = 1'b0;
            end
            default: begin
                next_q.mac_writes_dest = 1'b1;
            end
        endcase

        // The X bit has two readings; the datapath uses the one its format needs.
        next_q.coef_inc_by_index = instr[dfd_pkg::X_BIT];
        next_q.half_high = instr[dfd_pkg::X_BIT];

        // Indirect addressing with post-modification.
        next_q.ptr_sel = yz_code[3:2];
        case (yz_code[1:0])
            2'h1: begin
                next_q.ptr_mod = dfd_pkg::pm_inc1;
            end
            2'h3: begin
                next_q.ptr_mod = dfd_pkg::pm_incj;
            end
            default: begin
                next_q.ptr_mod = dfd_pkg::pm_none;
            end
        endcase

        // Compound addressing shares the same four bits.
        next_q.comp_ptr_sel = yz_code[3:2];
        next_q.comp_mode = dfd_pkg::dfd_comp_mode_t'(yz_code[1:0]);

        // Special function.
        next_q.sf_op = dfd_pkg::dfd_sf_op_t'(f2_code);

        // Condition evaluation against the flags supplied by the datapath.
        next_q.cond_code = cond_code;
        if (cond_code > dfd_pkg::COND_LAST) begin
            next_q.cond_reserved = 1'b1;
            next_q.cond_true = 1'b0;
        end else if (cond_code == dfd_pkg::COND_ALWAYS) begin
            next_q.cond_true = 1'b1;
        end else if (cond_code == dfd_pkg::COND_NEVER) begin
            next_q.cond_true = 1'b0;
        end else begin
            next_q.cond_true = cond_flags[cond_code];
        end

        // Data-move register target.
        next_q.move_reg = move_code;
        case (move_code)
            6'h0f, 6'h1e, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h39, 6'h3e: begin
                next_q.move_reserved = 1'b1;
            end
            default: begin
                next_q.move_reserved = 1'b0;
            end
        endcase
        if (move_code[5:2] == dfd_pkg::MOVE_PTR_BASE[5:2]) begin
            next_q.move_is_ptr = 1'b1;
        end
        if (move_code[5:2] == dfd_pkg::MOVE_ACC_BASE[5:2]) begin
            next_q.move_is_acc_half = 1'b1;
        end

        // Indirect branch type; a reserved type becomes no branch at all.
        if (br_code[2]) begin
            next_q.br_type = dfd_pkg::br_none;
            next_q.br_reserved = 1'b1;
        end else begin
            next_q.br_type = dfd_pkg::dfd_br_t'(br_code);
        end

        // Short immediate register pair; the type field picks the member.
        next_q.short_pair = instr[dfd_pkg::SHORT_LSB +: 2];

        // Qualifier or software interrupt.
        next_q.soft_int = instr[dfd_pkg::SOFT_INT_BIT];
        next_q.qualifier = ~instr[dfd_pkg::SOFT_INT_BIT];

        // Cache loop set-up.
        next_q.cache_count = ni_code;
        next_q.cache_redo = (ni_code == '0);
        if (k_code == '0) begin
            next_q.cache_iter = loop_count;
        end else begin
            next_q.cache_iter = k_code;
        end

        // Direct addressing.
        next_q.direct_read = instr[dfd_pkg::DIR_BIT];
        next_q.direct_reg = instr[dfd_pkg::DIRECT_REG_LSB +: dfd_pkg::DIRECT_REG_W];

        // Three-operand ALU; only codes with the top bit set and 1100 excluded.
        next_q.alu3_writes_dest = 1'b1;
        case (f3_code)
            4'h8: begin
                next_q.alu3_op = dfd_pkg::a3_or;
            end
            4'h9: begin
                next_q.alu3_op = dfd_pkg::a3_xor;
            end
            4'ha: begin
                next_q.alu3_op = dfd_pkg::a3_test_and;
                next_q.alu3_writes_dest = 1'b0;
            end
            4'hb: begin
                next_q.alu3_op = dfd_pkg::a3_test_sub;
                next_q.alu3_writes_dest = 1'b0;
            end
            4'hd: begin
                next_q.alu3_op = dfd_pkg::a3_add;
            end
            4'he: begin
                next_q.alu3_op = dfd_pkg::a3_and;
            end
            4'hf: begin
                next_q.alu3_op = dfd_pkg::a3_sub;
            end
            default: begin
                next_q.alu3_op = dfd_pkg::a3_none;
                next_q.alu3_writes_dest = 1'b0;
                next_q.alu3_reserved = 1'b1;
            end
        endcase
        next_q.alu3_src = dfd_pkg::dfd_src3_t'(instr[dfd_pkg::THREE_OPERAND_SOURCE_SELECT_LSB +: 2]);

        // Bit-manipulation unit. The low two auxiliary bits name ar0..ar3
        // wherever the encoding leaves them free.
        next_q.bmu_aux = aux_code[1:0];
        casez ({f4_code, aux_code})
            8'b0000_00??: begin
                next_q.bmu_op = dfd_pkg::bm_arith_r_aux;
            end
            8'b0001_00??: begin
                next_q.bmu_op = dfd_pkg::bm_arith_l_aux;
            end
            8'b0000_10??: begin
                next_q.bmu_op = dfd_pkg::bm_logic_r_aux;
            end
            8'b0001_10??: begin
                next_q.bmu_op = dfd_pkg::bm_logic_l_aux;
            end
            8'b1000_0000: begin
                next_q.bmu_op = dfd_pkg::bm_arith_r_src;
            end
            8'b1001_0000: begin
                next_q.bmu_op = dfd_pkg::bm_arith_l_src;
            end
            8'b1000_1000: begin
                next_q.bmu_op = dfd_pkg::bm_logic_r_src;
            end
            8'b1001_1000: begin
                next_q.bmu_op = dfd_pkg::bm_logic_l_src;
            end
            8'b1100_0000: begin
                next_q.bmu_op = dfd_pkg::bm_arith_r_imm;
            end
            8'b1101_0000: begin
                next_q.bmu_op = dfd_pkg::bm_arith_l_imm;
            end
            8'b1100_1000: begin
                next_q.bmu_op = dfd_pkg::bm_logic_r_imm;
            end
            8'b1101_1000: begin
                next_q.bmu_op = dfd_pkg::bm_logic_l_imm;
            end
            8'b0000_1100: begin
                next_q.bmu_op = dfd_pkg::bm_exp;
            end
            8'b0001_11??: begin
                next_q.bmu_op = dfd_pkg::bm_norm;
            end
            8'b1110_0000: begin
                next_q.bmu_op = dfd_pkg::bm_exts_imm;
            end
            8'b0010_00??: begin
                next_q.bmu_op = dfd_pkg::bm_exts_aux;
            end
            8'b1110_0100: begin
                next_q.bmu_op = dfd_pkg::bm_extz_imm;
            end
            8'b0010_01??: begin
                next_q.bmu_op = dfd_pkg::bm_extz_aux;
            end
            8'b1110_1000: begin
                next_q.bmu_op = dfd_pkg::bm_ins_imm;
            end
            8'b1010_10??: begin
                next_q.bmu_op = dfd_pkg::bm_ins_aux;
            end
            8'b0111_0000: begin
                next_q.bmu_op = dfd_pkg::bm_alt_acc0;
            end
            8'b0111_0001: begin
                next_q.bmu_op = dfd_pkg::bm_alt_acc1;
            end
            default: begin
                // Unlisted pairs must not reach the shifter at all.
                next_q.bmu_op = dfd_pkg::bm_none;
                next_q.bmu_reserved = 1'b1;
            end
        endcase

        next_q.jump_target = instr[dfd_pkg::JUMP_W-1:0];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign ctl = q;

endmodule

// *** dfd_decoder_properties.sv ***
/*
 * Concurrent checks on the instruction field decoder, watching its ports only.
 * Assumes one clock domain and that ctl answers each sampled word one edge later.
 */
module dfd_decoder_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [dfd_pkg::INSTR_W-1:0] instr,
    input wire logic [dfd_pkg::COND_N-1:0] cond_flags,
    input wire logic [dfd_pkg::K_W-1:0] loop_count,
    input wire dfd_pkg::dfd_ctl_t ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Every check is gated by the previous edge being out of reset, since
    // the word sampled during reset never reaches ctl.
    valid_drop_a: assert property (
        $past(rst_b) && $fell(instr_valid) |=> $fell(ctl.valid))
        else $error("valid did not drop one edge after the fetched word went away");
    acc_select_a: assert property (
        $past(rst_b) |-> ctl.src_acc == $past(instr[9]) && ctl.dest_acc == $past(instr[10])
            && ctl.xfer_acc != $past(instr[10]))
        else $error("accumulator selects wrong");
    mac_write_a: assert property (
        $past(rst_b) |-> ctl.mac_writes_dest == !($past(instr[8:5]) inside {2, 6, 10, 11}))
        else $error("multiply function write enable wrong");
    ptr_mod_a: assert property (
        $past(rst_b) |-> ctl.ptr_sel == $past(instr[3:2]) && ctl.ptr_mod ==
            ($past(instr[1:0]) == 2'h1 ? 2'h1 : $past(instr[1:0]) == 2'h3 ? 2'h2 : 2'h0))
        else $error("pointer post modification wrong");
    cond_eval_a: assert property (
        $past(rst_b) |-> ctl.cond_reserved == ($past(instr[4:0]) > dfd_pkg::COND_LAST)
            && ctl.cond_true == ($past(instr[4:0]) == dfd_pkg::COND_ALWAYS ? 1'b1 :
            ($past(instr[4:0]) == dfd_pkg::COND_NEVER || $past(instr[4:0]) > 5'h1c) ? 1'b0 :
            $past(cond_flags[instr[4:0]])))
        else $error("condition evaluation wrong");
    move_group_a: assert property (
        $past(rst_b) |-> ctl.move_is_ptr == ($past(instr[9:4]) < 6'h04)
            && ctl.move_is_acc_half == ($past(instr[9:4]) inside {[6'h30:6'h33]})
            && ctl.move_reserved == ($past(instr[9:4]) inside
                {6'h0f, 6'h1e, [6'h2c:6'h2f], 6'h39, 6'h3e}))
        else $error("move register group wrong");
    branch_type_a: assert property (
        $past(rst_b) && $past(instr[10]) |-> ctl.br_type == dfd_pkg::br_none && ctl.br_reserved)
        else $error("reserved branch type not neutral");
    soft_int_a: assert property (
        $past(rst_b) |-> ctl.soft_int == $past(instr[10]) && ctl.qualifier == !ctl.soft_int)
        else $error("software interrupt select wrong");
    cache_redo_a: assert property (
        $past(rst_b) |-> ctl.cache_count == $past(instr[10:7])
            && ctl.cache_redo == ($past(instr[10:7]) == 4'h0))
        else $error("cache count or redo wrong");
    cache_iter_a: assert property (
        $past(rst_b) |-> ctl.cache_iter ==
            ($past(instr[6:0]) == 7'h00 ? $past(loop_count) : $past(instr[6:0])))
        else $error("cache repeat count wrong");
    alu3_code_a: assert property (
        $past(rst_b) |-> ctl.alu3_writes_dest == ($past(instr[8:5]) inside {8, 9, 13, 14, 15})
            && ctl.alu3_reserved == (!$past(instr[8]) || $past(instr[8:5]) == 4'hc))
        else $error("three operand write or reserved flag wrong");
    redo_seen_c: cover property (ctl.valid && ctl.cache_redo);
endmodule

// *** dfd_fetch_model.sv ***
/*
 * Behavioural fetch stage and datapath flag source facing the decoder.
 * Assumes the bench hands it one word per cycle; it registers what it is given, but inverts the held word while fetch_en is low.
 */
module dfd_fetch_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [dfd_pkg::INSTR_W-1:0] fetch_word,
    input wire logic fetch_en,
    input wire logic [dfd_pkg::COND_N-1:0] flags_in,
    input wire logic [dfd_pkg::K_W-1:0] count_in,
    output logic [dfd_pkg::INSTR_W-1:0] instr,
    output logic instr_valid,
    output logic [dfd_pkg::COND_N-1:0] cond_flags,
    output logic [dfd_pkg::K_W-1:0] loop_count
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr <= '0;
            instr_valid <= 1'b0;
            cond_flags <= '0;
            loop_count <= '0;
        end else begin
            instr_valid <= fetch_en;
            // With no fetch the bus is not held: inverting it keeps the
            // decoder from seeing a stale word as a fresh one.
            instr <= fetch_en ? fetch_word : ~instr;
            cond_flags <= flags_in;
            loop_count <= count_in;
        end
    end
endmodule

// *** testbench.sv ***
/*
 * Self-checking bench for the instruction field decoder: a field sweep, the
 * hand-over walk word and random traffic, all back to back.
 * Assumes the fetch model adds one edge and the decoder one more.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] fetch_word = '0;
    logic fetch_en = 1'b0;
    logic [28:0] flags_in = '0;
    logic [6:0] count_in = '0;
    logic [15:0] instr;
    logic instr_valid;
    logic [28:0] cond_flags;
    logic [6:0] loop_count;
    dfd_pkg::dfd_ctl_t ctl;
    int error_cnt = 0;
    int cmp_count = 0;
    int filled = 0;
    logic [31:0] seed = 32'ha7a6a88f;
    logic [15:0] hw [3];
    logic hv [3];
    logic [28:0] hf [3];
    logic [6:0] hc [3];

    always #2.5 clk = ~clk;

    dfd_fetch_model fetch (.clk(clk), .rst_b(rst_b), .fetch_word(fetch_word),
        .fetch_en(fetch_en), .flags_in(flags_in), .count_in(count_in), .instr(instr),
        .instr_valid(instr_valid), .cond_flags(cond_flags), .loop_count(loop_count));
    dfd_decoder dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
        .cond_flags(cond_flags), .loop_count(loop_count), .ctl(ctl));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [6:0] exp_cond(input logic [4:0] c, input logic [28:0] f);
        if (c == 5'h0e) return {c, 2'b10};
        if (c == 5'h0f) return {c, 2'b00};
        if (c > 5'h1c) return {c, 2'b01};
        return {c, f[c], 1'b0};
    endfunction

    function automatic logic [4:0] exp_alu3(input logic [3:0] c);
        case (c)
            4'h8: return 5'h06;
            4'h9: return 5'h0a;
            4'ha: return 5'h0c;
            4'hb: return 5'h10;
            4'hd: return 5'h16;
            4'he: return 5'h1a;
            4'hf: return 5'h1e;
            default: return 5'h01;
        endcase
    endfunction

    // Returns the operation code and the reserved flag for {function, aux}.
    function automatic logic [5:0] exp_bmu(input logic [7:0] k);
        casez (k)
            8'b0000_00??: return {5'h01, 1'b0};
            8'b0001_00??: return {5'h02, 1'b0};
            8'b0000_10??: return {5'h03, 1'b0};
            8'b0001_10??: return {5'h04, 1'b0};
            8'b1000_0000: return {5'h05, 1'b0};
            8'b1001_0000: return {5'h06, 1'b0};
            8'b1000_1000: return {5'h07, 1'b0};
            8'b1001_1000: return {5'h08, 1'b0};
            8'b1100_0000: return {5'h09, 1'b0};
            8'b1101_0000: return {5'h0a, 1'b0};
            8'b1100_1000: return {5'h0b, 1'b0};
            8'b1101_1000: return {5'h0c, 1'b0};
            8'b0000_1100: return {5'h0d, 1'b0};
            8'b0001_11??: return {5'h0e, 1'b0};
            8'b1110_0000: return {5'h0f, 1'b0};
            8'b0010_00??: return {5'h10, 1'b0};
            8'b1110_0100: return {5'h11, 1'b0};
            8'b0010_01??: return {5'h12, 1'b0};
            8'b1110_1000: return {5'h13, 1'b0};
            8'b1010_10??: return {5'h14, 1'b0};
            8'b0111_0000: return {5'h15, 1'b0};
            8'b0111_0001: return {5'h16, 1'b0};
            default: return {5'h00, 1'b1};
        endcase
    endfunction

    task automatic check_ctl(input logic [15:0] w, input logic v, input logic [28:0] f,
                             input logic [6:0] c);
        logic [5:0] r;
        r = w[9:4];
        chk("valid", ctl.valid, v);
        if (v) begin
            chk("acc", {ctl.dest_acc, ctl.src_acc}, w[10:9]);
            chk("xfer", ctl.xfer_acc, !w[10]);
            chk("mac", {ctl.mac_op, ctl.mac_writes_dest},
                {w[8:5], !(w[8:5] inside {2, 6, 10, 11})});
            chk("xbit", {ctl.coef_inc_by_index, ctl.half_high}, {2{w[4]}});
            chk("ptr", {ctl.ptr_sel, ctl.ptr_mod},
                {w[3:2], w[1] & w[0], w[0] & ~w[1]});
            chk("comp", {ctl.comp_ptr_sel, ctl.comp_mode}, w[3:0]);
            chk("sf", ctl.sf_op, w[8:5]);
            chk("cond", {ctl.cond_code, ctl.cond_true, ctl.cond_reserved},
                exp_cond(w[4:0], f));
            chk("move", {ctl.move_reg, ctl.move_is_ptr, ctl.move_is_acc_half, ctl.move_reserved},
                {r, r < 6'h04, r inside {[6'h30:6'h33]},
                r inside {6'h0f, 6'h1e, [6'h2c:6'h2f], 6'h39, 6'h3e}});
            chk("branch", {ctl.br_type, ctl.br_reserved},
                w[10] ? 4'h9 : {w[10:8], 1'b0});
            chk("short", ctl.short_pair, w[10:9]);
            chk("soft", {ctl.soft_int, ctl.qualifier}, {w[10], !w[10]});
            chk("cache", {ctl.cache_count, ctl.cache_redo},
                {w[10:7], w[10:7] == 4'h0});
            chk("iter", ctl.cache_iter, w[6:0] == 7'h00 ? c : w[6:0]);
            chk("direct", {ctl.direct_read, ctl.direct_reg}, w[10:6]);
            chk("alu3", {ctl.alu3_op, ctl.alu3_writes_dest, ctl.alu3_reserved},
                exp_alu3(w[8:5]));
            chk("src3", ctl.alu3_src, w[4:3]);
            chk("bmu", {ctl.bmu_op, ctl.bmu_reserved, ctl.bmu_aux},
                {exp_bmu({w[8:6], w[4], w[3:0]}), w[1:0]});
            chk("jump", ctl.jump_target, w[11:0]);
        end
    endtask

    // Drives one word per edge and checks the word driven two edges earlier.
    task automatic step(input logic [15:0] w, input logic v);
        logic [31:0] a;
        logic [31:0] b;
        a = $random(seed);
        b = $random(seed);
        @(posedge clk);
        fetch_word <= w;
        fetch_en <= v;
        flags_in <= a[28:0];
        count_in <= b[6:0];
        for (int i = 2; i > 0; i--) begin
            hw[i] = hw[i - 1];
            hv[i] = hv[i - 1];
            hf[i] = hf[i - 1];
            hc[i] = hc[i - 1];
        end
        hw[0] = w;
        hv[0] = v;
        hf[0] = a[28:0];
        hc[0] = b[6:0];
        #1;
        filled++;
        if (filled >= 3) check_ctl(hw[2], hv[2], hf[2], hc[2]);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #20000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        logic [31:0] r;
        repeat (16) @(posedge clk);
        #1;
        chk("reset", ctl == '0, 1'b1);
        rst_b <= 1'b1;
        step(16'h0c21, 1'b1);
        step(16'h0c21, 1'b0);
        step(16'h0000, 1'b1);
        step(16'h0780, 1'b1);
        // Sweep every condition and bit-manipulation key; function bits 8:6 are swept, bit 5 is random.
        for (int i = 0; i < 256; i++) begin
            r = $random(seed);
            step({r[15:9], i[7:5], r[5], i[4:0]}, 1'b1);
        end
        for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            step(r[15:0], r[19:17] != 3'h0);
        end
        step(16'h0000, 1'b0);
        step(16'h0000, 1'b0);
        wrap_up();
    end
endmodule

bind dfd_decoder dfd_decoder_checker u_chk (.clk(clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr(instr), .cond_flags(cond_flags),
    .loop_count(loop_count), .ctl(ctl));
